// >>> inc/shift_port_params.svh
// offsets, field positions, reset values and timing counts of the shift port
// assumes: included by bare name from the end modules only; the package does not include it
`ifndef SHIFT_PORT_PARAMS_SVH
`define SHIFT_PORT_PARAMS_SVH
`define SP_ADDR_DATA 2'h0
`define SP_ADDR_STATUS 2'h1
`define SP_ADDR_CTRL 2'h2
`define SP_ADDR_DIR 2'h3
`define SP_ST_FLAG 7
`define SP_CTL_IRQ_EN 6
`define SP_CTL_WM_HI 5
`define SP_CTL_WM_LO 4
`define SP_CTL_SRC_HI 3
`define SP_CTL_EDGE 2
`define SP_CTL_SWCLK 1
`define SP_CTL_TOGGLE 0
`define SP_DIR_DO 0
`define SP_DIR_SCK 1
`define SP_DATA_RST 8'h00
`define SP_CTRL_RST 8'h00
`define SP_DIR_RST 2'h0
`define SP_SYS_MHZ 200
`define SP_HALF_NS 40
`define SP_HALF_CYC ((`SP_HALF_NS * `SP_SYS_MHZ + 999) / 1000)
`endif

// >>> inc/shift_port_pkg.sv
// state types of the shift port ends
// assumes: compiled before the interface and the modules
package shift_port_pkg;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SETUP = 2'b01,
      H_RUN = 2'b10,
      H_DONE = 2'b11
   } host_state_t;

   typedef struct packed {
      logic first;
      logic second;
   } sync_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic out_bit;
      logic [3:0] count;
      logic flag;
      logic [7:0] ctrl;
      logic [1:0] dir;
      logic sck_drv;
      logic sck_prev;
      logic [7:0] rdata;
   } dev_state_t;

   typedef struct packed {
      host_state_t state;
      logic [7:0] div;
      logic [3:0] edges;
      logic [7:0] shift;
      logic out_bit;
      logic sck;
      logic [7:0] rx;
      logic done;
   } host_state_struct_t;
endpackage : shift_port_pkg

// >>> inc/shift_link_if.sv
// three-wire link between the shift port and the remote party
// assumes: the bench instantiates it; an undriven line reads low
`timescale 1ns/1ps
interface shift_link_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_do_o;
   logic dev_do_oe;
   logic far_sck_o;
   logic far_sck_oe;
   logic far_do_o;
   logic far_do_oe;
   logic serial_clock_line;
   logic serial_in_pin;
   logic far_in_pin;

   assign serial_clock_line = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b0);
   assign serial_in_pin = far_do_oe ? far_do_o : 1'b0;
   assign far_in_pin = dev_do_oe ? dev_do_o : 1'b0;

   modport device_end (
      output dev_sck_o, dev_sck_oe, dev_do_o, dev_do_oe,
      input serial_clock_line, serial_in_pin
   );
   modport far_end (
      output far_sck_o, far_sck_oe, far_do_o, far_do_oe,
      input serial_clock_line, far_in_pin
   );
endinterface : shift_link_if

// >>> logic/level_sync.sv
// two flip-flop synchroniser for one pin level
// assumes: async_in comes from outside the clk_in domain
`timescale 1ns/1ps
module level_sync (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic async_in,
   output logic sync_out
);
   import shift_port_pkg::*;
   sync_state_t s;
   sync_state_t next_s;

   always_comb begin
      next_s.first = async_in;
      next_s.second = s.first;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.second;
endmodule : level_sync

// >>> logic/shift_port_device.sv
// What this block does
// - one 8-bit shift data register, bus accessible
// - msb drives pin chosen by wire mode
// - output latch changes on opposite edge
// - input always from serial input pin
// - one bit shifted per serial clock
// - edge select 0: sample rise, change fall
// - edge select 1: sample fall, change rise
// - settings equal SPI modes 0 and 1
// - first bit set up half period early
// - link output driven only when direction set; alt pin driven regardless
// - counter cleared to zero before transfer
// - master toggles clock twice per bit
// - counter counts rising and falling edges
// - sixteen edges overflow, set the flag
// - enabled overflow raises an interrupt
// - read byte before next transfer starts
// - slave may release output after transfer
// - slave software polls flag, then reads
// - serial clock at most half system clock
//
// shift port end: registers on a plain strobe port, link on shift_link_if
// assumes: serial clock edges no closer than a few clk_in cycles
`timescale 1ns/1ps
`include "shift_port_params.svh"
module shift_port_device (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   shift_link_if.device_end link,
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic alt_data_out,
   output logic irq_out
);
   import shift_port_pkg::*;

   localparam dev_state_t DEV_RST = '{
      data: `SP_DATA_RST,
      ctrl: `SP_CTRL_RST,
      dir: `SP_DIR_RST,
      default: '0
   };

   dev_state_t s;
   dev_state_t next_s;
   logic sck_sync;
   logic di_sync;
   logic rise;
   logic fall;
   logic ext_src;
   logic sw_step;
   logic sample_ev;
   logic change_ev;
   logic count_ev;
   logic wr_data;
   logic wr_status;
   logic wr_ctrl;
   logic [4:0] count_sum;
   logic [7:0] shifted;
   logic set_flag;

   level_sync sck_sync_u (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(link.serial_clock_line),
      .sync_out(sck_sync)
   );

   level_sync di_sync_u (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(link.serial_in_pin),
      .sync_out(di_sync)
   );

   always_comb begin
      next_s = s;
      wr_data = wr_in && (addr_in == `SP_ADDR_DATA);
      wr_status = wr_in && (addr_in == `SP_ADDR_STATUS);
      wr_ctrl = wr_in && (addr_in == `SP_ADDR_CTRL);
      rise = sck_sync && !s.sck_prev;
      fall = !sck_sync && s.sck_prev;
      next_s.sck_prev = sck_sync;
      ext_src = s.ctrl[`SP_CTL_SRC_HI];
      // software clock: one strobe is one whole clock cycle
      sw_step = wr_ctrl && wdata_in[`SP_CTL_SWCLK] && !ext_src;
      sample_ev = ext_src ? (s.ctrl[`SP_CTL_EDGE] ? fall : rise) : sw_step;
      change_ev = ext_src ? (s.ctrl[`SP_CTL_EDGE] ? rise : fall) : sw_step;
      count_ev = ext_src ? (rise || fall) : sw_step;
      shifted = {s.data[6:0], di_sync};

      if (sample_ev) begin
         next_s.data = shifted;
      end
      // latch follows msb on the change edge and on a data write
      if (change_ev) begin
         next_s.out_bit = sample_ev ? shifted[7] : s.data[7];
      end
      if (wr_data) begin
         next_s.data = wdata_in;
         next_s.out_bit = wdata_in[7];
      end

      count_sum = {1'b0, s.count} + (sw_step ? 5'h02 : 5'h01);
      set_flag = count_ev && count_sum[4];
      if (count_ev) begin
         next_s.count = count_sum[3:0];
      end
      if (wr_status) begin
         next_s.count = wdata_in[3:0];
         if (wdata_in[`SP_ST_FLAG]) begin
            next_s.flag = 1'b0;
         end
      end
      if (set_flag) begin
         next_s.flag = 1'b1;
      end

      if (wr_ctrl) begin
         next_s.ctrl = {wdata_in[7:1], 1'b0};
         if (wdata_in[`SP_CTL_TOGGLE]) begin
            next_s.sck_drv = !s.sck_drv;
         end
      end
      if (wr_in && (addr_in == `SP_ADDR_DIR)) begin
         next_s.dir = wdata_in[1:0];
      end

      next_s.rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            `SP_ADDR_DATA: next_s.rdata = s.data;
            `SP_ADDR_STATUS: next_s.rdata = {s.flag, 3'h0, s.count};
            `SP_ADDR_CTRL: next_s.rdata = s.ctrl;
            `SP_ADDR_DIR: next_s.rdata = {6'h00, s.dir};
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s <= DEV_RST;
      end else begin
         s <= next_s;
      end
   end

   // three-wire mode routes the msb to the link, mode hi to the other pin
   assign link.dev_do_o = s.out_bit && (s.ctrl[`SP_CTL_WM_HI:`SP_CTL_WM_LO] == 2'b01);
   assign link.dev_do_oe = s.dir[`SP_DIR_DO]
      && (s.ctrl[`SP_CTL_WM_HI:`SP_CTL_WM_LO] == 2'b01);
   assign alt_data_out = s.out_bit && s.ctrl[`SP_CTL_WM_HI];
   assign link.dev_sck_o = s.sck_drv;
   assign link.dev_sck_oe = s.dir[`SP_DIR_SCK];
   assign rdata_out = s.rdata;
   assign irq_out = s.flag && s.ctrl[`SP_CTL_IRQ_EN];
endmodule : shift_port_device

// >>> logic/shift_port_far.sv
// remote party: master that clocks one byte through the link per start
// assumes: start_in pulses from logic on clk_in; device is a slave
`timescale 1ns/1ps
`include "shift_port_params.svh"
module shift_port_far #(
   parameter logic [7:0] HALF_CYC = 8'(`SP_HALF_CYC)
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   shift_link_if.far_end link,
   input wire logic master_en_in,
   input wire logic start_in,
   input wire logic mode_in,
   input wire logic [7:0] tx_in,
   output logic [7:0] rx_out,
   output logic done_out,
   output logic busy_out
);
   import shift_port_pkg::*;

   host_state_struct_t s;
   host_state_struct_t next_s;
   logic di_sync;
   logic tick;
   logic sample_edge;
   logic mode;

   level_sync di_sync_u (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(link.far_in_pin),
      .sync_out(di_sync)
   );

   // phase of the byte: mode 1 starts on an odd count, so parity against the clock level shows it
   assign mode = s.sck ? !s.edges[0] : s.edges[0];

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      tick = (s.div == HALF_CYC - 8'h01);
      // first edge of each pair samples in mode 0, second in mode 1
      sample_edge = (s.edges[0] == 1'b0);
      unique case (s.state)
         H_IDLE: begin
            next_s.sck = 1'b0;
            next_s.div = 8'h00;
            if (start_in) begin
               next_s.shift = tx_in;
               next_s.out_bit = tx_in[7];
               next_s.edges = {3'h0, mode_in};
               next_s.state = H_SETUP;
            end
         end
         H_SETUP: begin
            // data and driver settle a whole period (setup half plus first run half) before the first edge
            next_s.div = tick ? 8'h00 : s.div + 8'h01;
            if (tick) begin
               next_s.state = H_RUN;
            end
         end
         H_RUN: begin
            next_s.div = tick ? 8'h00 : s.div + 8'h01;
            if (tick) begin
               next_s.sck = !s.sck;
               next_s.edges = s.edges + 4'h1;
               if (sample_edge) begin
                  next_s.shift = {s.shift[6:0], di_sync};
               end else begin
                  next_s.out_bit = s.shift[7];
               end
               // sixteenth edge: count 15 in mode 0, wrapped to 0 in mode 1
               if (s.sck && (s.edges == (mode ? 4'h0 : 4'hf))) begin
                  next_s.state = H_DONE;
               end
            end
         end
         H_DONE: begin
            next_s.rx = s.shift;
            next_s.done = 1'b1;
            next_s.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s <= '{state: H_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign link.far_sck_o = s.sck;
   assign link.far_sck_oe = master_en_in;
   assign link.far_do_o = s.out_bit;
   // keep driving through the done cycle so the slave still sees the last bit
   assign link.far_do_oe = (s.state != H_IDLE);
   assign rx_out = s.rx;
   assign done_out = s.done;
   assign busy_out = (s.state != H_IDLE);
endmodule : shift_port_far

// >>> test/shift_port_assertions.sv
// link checks between the shift port and its far-end master
// assumes: far half period of 6 clk_in cycles; wired beside the link
`timescale 1ns/1ps
module shift_port_assertions (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic dev_sck_oe,
   input wire logic dev_do_o,
   input wire logic dev_do_oe,
   input wire logic far_sck_o,
   input wire logic far_sck_oe,
   input wire logic far_do_oe
);
   logic [3:0] quiet;
   logic [4:0] edges;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // edges of one transfer, forgotten once the clock has rested
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         quiet <= 4'h0;
         edges <= 5'h00;
      end else if ($changed(far_sck_o)) begin
         quiet <= 4'h0;
         edges <= edges + 5'h01;
      end else if (quiet != 4'hf) begin
         quiet <= quiet + 4'h1;
      end else begin
         edges <= 5'h00;
      end
   end
   a_far_half_hold: assert property (
      $changed(far_sck_o) |=> $stable(far_sck_o) [*5]) else $error("far clock too fast");
   a_far_data_setup: assert property (
      $rose(far_do_oe) |-> $stable(far_sck_o) [*5]) else $error("far data set up late");
   a_dev_first_bit: assert property (
      $changed(far_sck_o) && far_sck_oe && dev_do_oe |-> $past(dev_do_oe, 5))
      else $error("device output enabled late");
   a_do_steady_edge: assert property (
      $changed(far_sck_o) && far_sck_oe && !dev_sck_oe |-> $stable(dev_do_o))
      else $error("device output moved on a clock edge");
   a_do_one_move: assert property (
      $changed(dev_do_o) && far_sck_oe && !dev_sck_oe |=> $stable(dev_do_o) [*3])
      else $error("device output moved twice in a half period");
   a_do_drive_kept: assert property (
      $changed(far_sck_o) && far_sck_oe |-> dev_do_oe == $past(dev_do_oe))
      else $error("device drive changed in a transfer");
   a_far_idle_low: assert property (
      $stable(far_sck_o) [*8] |-> !far_sck_o) else $error("far clock rests high");
   a_far_16_edges: assert property (
      quiet == 4'he |-> edges == 5'h00 || edges == 5'h10) else $error("edge count not 16");
endmodule : shift_port_assertions

// >>> test/testbench.sv
// self-checking bench: shift port facing its far-end master
// assumes: 200 MHz clk_in; far half period shortened to 6 cycles
`timescale 1ns/1ps
module testbench;
   import shift_port_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic m_en = 1'b0;
   logic start = 1'b0;
   logic mode = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [7:0] rdata, rx;
   logic alt, irq, done, busy;
   int n_errors = 0;
   int total_checks = 0;
   shift_link_if link ();
   shift_port_device u_shift_port_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .link(link.device_end), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .alt_data_out(alt), .irq_out(irq));
   shift_port_far #(.HALF_CYC(8'h06)) u_shift_port_far (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .link(link.far_end), .master_en_in(m_en), .start_in(start),
      .mode_in(mode), .tx_in(tx), .rx_out(rx), .done_out(done), .busy_out(busy));
   shift_port_assertions u_shift_port_assertions (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .dev_sck_oe(link.dev_sck_oe), .dev_do_o(link.dev_do_o), .dev_do_oe(link.dev_do_oe),
      .far_sck_o(link.far_sck_o), .far_sck_oe(link.far_sck_oe), .far_do_oe(link.far_do_oe));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_reg
   task automatic xfer(input logic m, input logic [7:0] dtx, input logic [7:0] ftx);
      int i;
      wr_reg(2'h2, {1'b0, m, 2'b01, 1'b1, m, 2'b00});
      wr_reg(2'h3, 8'h01);
      wr_reg(2'h1, 8'h80);
      wr_reg(2'h0, dtx);
      @(posedge clk_in);
      m_en <= 1'b1;
      mode <= m;
      tx <= ftx;
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 300) begin
         @(posedge clk_in);
         i++;
      end
      if (i == 300) begin
         n_errors++;
         $display("[ERR] %0t ns: far end never finished", $time);
      end
      repeat (8) @(posedge clk_in);
      m_en <= 1'b0;
      chk(rx, dtx);
      rd_reg(2'h0, ftx);
      rd_reg(2'h1, 8'h80);
      chk({7'h00, irq}, {7'h00, m});
      wr_reg(2'h1, 8'h00);
      rd_reg(2'h1, 8'h80);
      wr_reg(2'h1, 8'h80);
      rd_reg(2'h1, 8'h00);
   endtask : xfer
   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         rd_reg(2'(a), 8'h00);
      end
      $display("reset values done");
      wr_reg(2'h3, 8'h01);
      wr_reg(2'h2, 8'h20);
      wr_reg(2'h0, 8'h80);
      #1 chk({6'h00, link.dev_do_oe, alt}, 8'h01);
      rd_reg(2'h0, 8'h80);
      wr_reg(2'h2, 8'h10);
      #1 chk({5'h00, link.dev_do_oe, link.dev_do_o, alt}, 8'h06);
      wr_reg(2'h3, 8'h00);
      #1 chk({6'h00, link.dev_do_oe, alt}, 8'h00);
      $display("output pin choice done");
      for (int m = 0; m < 2; m++) begin
         xfer(m[0], 8'ha6 + 8'(m), 8'h59 - 8'(m));
         xfer(m[0], 8'h3c, 8'hc1);
      end
      $display("link transfers done");
      wr_reg(2'h3, 8'h02);
      wr_reg(2'h2, 8'h10);
      wr_reg(2'h1, 8'h00);
      wr_reg(2'h2, 8'h13);
      #1 chk({7'h00, link.dev_sck_o}, 8'h01);
      rd_reg(2'h1, 8'h02);
      repeat (7) wr_reg(2'h2, 8'h13);
      #1 chk({7'h00, link.dev_sck_o}, 8'h00);
      rd_reg(2'h1, 8'h80);
      $display("software clock done");
      tally_and_finish();
   end
   initial begin
      #50000;
      n_errors++;
      tally_and_finish();
   end
endmodule : testbench
